// >>> include/cpu_data_pkg.sv
package cpu_data_pkg;

  // Bus geometry
  localparam int LANES        = 4;
  localparam int DATA_W       = 64;
  localparam int CHECK_W      = 8;
  localparam int LANE_DATA_W  = 16;
  localparam int LANE_CHECK_W = 2;

  // Core clock, which is also the bus reference clock
  localparam int CORE_CLK_KHZ = 10_000;

  // Reference clock rates the clock generation accepts, in kHz
  localparam int REF_RATE_LOW_KHZ  = 66_670;
  localparam int REF_RATE_MID_KHZ  = 100_000;
  localparam int REF_RATE_HIGH_KHZ = 133_330;

  // Outgoing strobe period and its half period in core cycles
  localparam int STROBE_PERIOD_NS = 800;
  localparam int STROBE_HALF_CYCLES = (STROBE_PERIOD_NS / 2) * CORE_CLK_KHZ / 1_000_000;
  localparam logic [3:0] STROBE_HALF_LAST = 4'(STROBE_HALF_CYCLES - 1);

  // Forward-clock init hold after chip reset, then delay before strobes run
  localparam logic [3:0] FWD_INIT_HOLD_LAST   = 4'h7;
  localparam logic [3:0] STROBE_START_LAST    = 4'h2;

  // Pin levels of active-low lines
  localparam logic STROBE_INACTIVE_N = 1'b1;
  localparam logic VALID_ASSERTED_N  = 1'b0;
  localparam logic VALID_NEGATED_N   = 1'b1;

  // One lane: 16 data bits and 2 check bits
  typedef struct packed {
    logic [LANE_CHECK_W-1:0] check;
    logic [LANE_DATA_W-1:0]  data;
  } lane_t;

  // One bus word with its check bits
  typedef struct packed {
    logic [CHECK_W-1:0] check;
    logic [DATA_W-1:0]  data;
  } word_t;

  // Pair of words moved as one paced unit
  typedef struct packed {
    word_t second;
    word_t first;
  } pair_t;

  // Forward-clock init sequence
  typedef enum logic [1:0] {
    INIT_HOLD,
    INIT_DELAY,
    INIT_RUN
  } init_state_t;

endpackage

// >>> design/strobe_lane_capture.sv
`timescale 1ns/1ps
// Synchronises the processor strobes and lanes, captures a lane per strobe edge
module strobe_lane_capture
  import cpu_data_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic [LANES-1:0]      strobes_n_in,
  input  wire logic [DATA_W-1:0]     data_n_in,
  input  wire logic [CHECK_W-1:0]    check_n_in,
  output lane_t     [LANES-1:0]      lane_word_out,
  output logic      [LANES-1:0]      lane_pulse_out
);

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [3:0] strobe_sync_reg;          // Strobe chain, bit 0 is the first flop
      logic [3:0] strobe_sync_next;
      lane_t      lane_s1_reg;              // First data flop, read only by the second
      lane_t      lane_s2_reg;              // Second data flop
      lane_t      lane_s1_next;
      lane_t      lane_s2_next;
      lane_t      word_reg;                 // Captured lane, true polarity
      lane_t      word_next;
      logic       pulse_reg;                // One cycle per captured edge
      logic       pulse_next;

      // Next values; data is taken one sample after the strobe sample
      // so a lane that changes with its strobe is already settled
      always_comb begin
        strobe_sync_next = {strobe_sync_reg[2:0], strobes_n_in[g]};
        lane_s1_next     = {check_n_in[g*LANE_CHECK_W +: LANE_CHECK_W],
                            data_n_in[g*LANE_DATA_W +: LANE_DATA_W]};
        lane_s2_next     = lane_s1_reg;
        word_next        = word_reg;
        pulse_next       = 1'b0;
        if (strobe_sync_reg[3] != strobe_sync_reg[2]) begin  // Both edges carry data
          word_next  = ~lane_s2_reg;                        // Pins are active low
          pulse_next = 1'b1;
        end
      end

      // Registers
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          strobe_sync_reg <= {4{STROBE_INACTIVE_N}};
          lane_s1_reg     <= '0;
          lane_s2_reg     <= '0;
          word_reg        <= '0;
          pulse_reg       <= 1'b0;
        end else begin
          strobe_sync_reg <= strobe_sync_next;
          lane_s1_reg     <= lane_s1_next;
          lane_s2_reg     <= lane_s2_next;
          word_reg        <= word_next;
          pulse_reg       <= pulse_next;
        end
      end

      assign lane_word_out[g]  = word_reg;
      assign lane_pulse_out[g] = pulse_reg;
    end
  endgenerate

endmodule

// >>> design/cpu_bus_data_channel.sv
`timescale 1ns/1ps
// Functional notes
// - Drive check bits with each outgoing word
// - Capture incoming check bits every strobe edge
// - Capture incoming data every strobe edge
// - Drive data bus with each outgoing word
// - Float data and check lines during reset
// - Processor drives writes, controller drives reads
// - Hold last values between transfers, never float
// - Each strobe qualifies 16 data, 2 check
// - One word per strobe edge, both edges
// - Strobes inactive in init, run three clocks later
// - Data-valid paces pairs, idle gaps allowed
// - Data-valid aligned to command strobe
// - Reference clock 66.67, 100 or 133.33 MHz; the core clock here is 10 MHz
// - Init output negated after reset, reference-clocked
module cpu_bus_data_channel
  import cpu_data_pkg::*;
(
  input  wire logic                            CLOCK_IN,
  input  wire logic                            RST_IN,
  input  wire logic [cpu_data_pkg::DATA_W-1:0]  CPU_DATA_LINES_N_IN,
  output logic      [cpu_data_pkg::DATA_W-1:0]  CPU_DATA_LINES_N_OUT,
  output logic                                 CPU_DATA_LINES_OE_OUT,
  input  wire logic [cpu_data_pkg::CHECK_W-1:0] ECC_CHECK_LINES_N_IN,
  output logic      [cpu_data_pkg::CHECK_W-1:0] ECC_CHECK_LINES_N_OUT,
  output logic                                 ECC_CHECK_LINES_OE_OUT,
  input  wire logic [cpu_data_pkg::LANES-1:0]   FROM_CPU_DATA_STROBES_N_IN,
  output logic      [cpu_data_pkg::LANES-1:0]   TO_CPU_DATA_STROBES_N_OUT,
  output logic                                 TO_CPU_COMMAND_STROBE_N_OUT,
  output logic                                 TO_CPU_DATA_VALID_N_OUT,
  output logic                                 FORWARD_CLOCK_INIT_OUT,
  input  wire logic                            RELEASE_BUS_IN,
  input  wire cpu_data_pkg::pair_t             RD_PAIR_IN,
  input  wire logic                            RD_PAIR_VALID_IN,
  output logic                                 RD_PAIR_READY_OUT,
  output cpu_data_pkg::word_t                  WR_WORD_OUT,
  output logic                                 WR_WORD_VALID_OUT
);

  import cpu_data_pkg::*;

  // Accepted reference rates; the core clock must be one of them in silicon,
  // the bench runs slower so the check is only a flag for tools to
  localparam bit REF_RATE_SUPPORTED = (CORE_CLK_KHZ == REF_RATE_LOW_KHZ) ||
                                      (CORE_CLK_KHZ == REF_RATE_MID_KHZ) ||
                                      (CORE_CLK_KHZ == REF_RATE_HIGH_KHZ);

  // Init sequencer state
  init_state_t init_state_reg;           // Forward-clock init phase
  init_state_t init_state_next;
  logic [3:0]  init_cnt_reg;             // Clocks spent in the phase
  logic [3:0]  init_cnt_next;
  logic        fwd_init_reg;             // Forward-clock init output
  logic        fwd_init_next;

  // Strobe divider state
  logic [3:0]  half_cnt_reg;             // Position inside a strobe half period
  logic [3:0]  half_cnt_next;
  logic        strobe_n_reg;             // Shared level of all outgoing strobes
  logic        strobe_n_next;
  logic        edge_tick;                // Next cycle carries a strobe edge

  // Transmit state
  pair_t       pend_pair_reg;            // Pair waiting for a period start
  pair_t       pend_pair_next;
  logic        pend_valid_reg;
  logic        pend_valid_next;
  word_t       second_reg;               // Second word of the pair in flight
  word_t       second_next;
  logic        second_due_reg;           // Next edge sends the second word
  logic        second_due_next;
  logic [DATA_W-1:0]  data_n_reg;        // Pin image of the data lines
  logic [DATA_W-1:0]  data_n_next;
  logic [CHECK_W-1:0] check_n_reg;       // Pin image of the check lines
  logic [CHECK_W-1:0] check_n_next;
  logic        valid_n_reg;              // Data-valid pin image
  logic        valid_n_next;
  logic        rd_take;                  // Pair handshake completes this cycle

  // Receive state
  lane_t [LANES-1:0] lane_word;          // Synchronised lane captures
  logic  [LANES-1:0] lane_pulse;
  word_t             wr_word_reg;        // Assembled write word
  word_t             wr_word_next;
  logic  [LANES-1:0] lane_have_reg;      // Lanes already captured for this word
  logic  [LANES-1:0] lane_have_next;
  logic              wr_valid_reg;
  logic              wr_valid_next;

  // Init sequence: hold init, release it, then start strobes three clocks on
  always_comb begin
    init_state_next = init_state_reg;
    init_cnt_next   = init_cnt_reg + 4'h1;
    fwd_init_next   = fwd_init_reg;
    case (init_state_reg)
      INIT_HOLD: begin
        if (init_cnt_reg == FWD_INIT_HOLD_LAST) begin
          init_state_next = INIT_DELAY;
          init_cnt_next   = '0;
          fwd_init_next   = 1'b0;                   // Negated on a reference edge
        end
      end
      INIT_DELAY: begin
        if (init_cnt_reg == STROBE_START_LAST) begin  // Three clocks after negation
          init_state_next = INIT_RUN;
          init_cnt_next   = '0;
        end
      end
      default: begin
        init_cnt_next = '0;                          // Running: counter parked
      end
    endcase
  end

  // Init registers; chip reset reasserts the init output
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      init_state_reg <= INIT_HOLD;
      init_cnt_reg   <= '0;
      fwd_init_reg   <= 1'b1;
    end else begin
      init_state_reg <= init_state_next;
      init_cnt_reg   <= init_cnt_next;
      fwd_init_reg   <= fwd_init_next;
    end
  end

  // Strobe divider: free-running once started, inactive before
  always_comb begin
    edge_tick     = (init_state_reg == INIT_RUN) && (half_cnt_reg == STROBE_HALF_LAST);
    half_cnt_next = '0;
    strobe_n_next = STROBE_INACTIVE_N;
    if (init_state_reg == INIT_RUN) begin
      half_cnt_next = edge_tick ? 4'h0 : half_cnt_reg + 4'h1;
      strobe_n_next = edge_tick ? ~strobe_n_reg : strobe_n_reg;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      half_cnt_reg <= '0;
      strobe_n_reg <= STROBE_INACTIVE_N;
    end else begin
      half_cnt_reg <= half_cnt_next;
      strobe_n_reg <= strobe_n_next;
    end
  end

  // A pair is taken only while the holding register is free
  assign rd_take           = RD_PAIR_VALID_IN && RD_PAIR_READY_OUT;
  assign RD_PAIR_READY_OUT = (init_state_reg == INIT_RUN) && !pend_valid_reg;

  // Transmit: a pair starts on a falling strobe edge and ends on the
  // rising one, so a pair always fills one whole strobe period
  always_comb begin
    pend_pair_next  = pend_pair_reg;
    pend_valid_next = pend_valid_reg;
    second_next     = second_reg;
    second_due_next = second_due_reg;
    data_n_next     = data_n_reg;                  // Hold last value between pairs
    check_n_next    = check_n_reg;
    valid_n_next    = valid_n_reg;
    if (rd_take) begin
      pend_pair_next  = RD_PAIR_IN;
      pend_valid_next = 1'b1;
    end
    if (edge_tick) begin
      if (second_due_reg) begin
        data_n_next     = ~second_reg.data;        // Second word on the rising edge
        check_n_next    = ~second_reg.check;
        second_due_next = 1'b0;
      end else if (strobe_n_reg == STROBE_INACTIVE_N) begin
        if (pend_valid_reg) begin
          data_n_next     = ~pend_pair_reg.first.data;
          check_n_next    = ~pend_pair_reg.first.check;
          second_next     = pend_pair_reg.second;
          second_due_next = 1'b1;
          pend_valid_next = 1'b0;
          valid_n_next    = VALID_ASSERTED_N;
        end else begin
          valid_n_next = VALID_NEGATED_N;                // Idle period between pairs
        end
      end
    end
  end

  // Transmit registers; data-valid moves only with the command strobe
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pend_pair_reg  <= '0;
      pend_valid_reg <= 1'b0;
      second_reg     <= '0;
      second_due_reg <= 1'b0;
      data_n_reg     <= '1;
      check_n_reg    <= '1;
      valid_n_reg    <= VALID_NEGATED_N;
    end else begin
      pend_pair_reg  <= pend_pair_next;
      pend_valid_reg <= pend_valid_next;
      second_reg     <= second_next;
      second_due_reg <= second_due_next;
      data_n_reg     <= data_n_next;
      check_n_reg    <= check_n_next;
      valid_n_reg    <= valid_n_next;
    end
  end

  // Pins; the bus is released in reset and while the processor writes
  assign CPU_DATA_LINES_N_OUT        = data_n_reg;
  assign ECC_CHECK_LINES_N_OUT       = check_n_reg;
  assign CPU_DATA_LINES_OE_OUT       = !RST_IN && !RELEASE_BUS_IN;
  assign ECC_CHECK_LINES_OE_OUT      = !RST_IN && !RELEASE_BUS_IN;
  assign TO_CPU_DATA_STROBES_N_OUT   = {LANES{strobe_n_reg}};       // One strobe per lane
  assign TO_CPU_COMMAND_STROBE_N_OUT = strobe_n_reg;
  assign TO_CPU_DATA_VALID_N_OUT     = valid_n_reg;
  assign FORWARD_CLOCK_INIT_OUT      = fwd_init_reg;

  // Incoming strobes and lanes cross into the core clock here; the
  // processor keeps its strobes quiet until its own start delay
  strobe_lane_capture u_capture (
    .clk_in         (CLOCK_IN),
    .rst_in         (RST_IN),
    .strobes_n_in   (FROM_CPU_DATA_STROBES_N_IN),
    .data_n_in      (CPU_DATA_LINES_N_IN),
    .check_n_in     (ECC_CHECK_LINES_N_IN),
    .lane_word_out  (lane_word),
    .lane_pulse_out (lane_pulse)
  );

  // Write word assembly: a word leaves when every lane has been captured;
  // a lane that edges twice first overwrites its earlier capture
  always_comb begin
    wr_word_next   = wr_word_reg;
    lane_have_next = lane_have_reg | lane_pulse;
    wr_valid_next  = 1'b0;
    for (int i = 0; i < LANES; i++) begin
      if (lane_pulse[i]) begin
        wr_word_next.data[i*LANE_DATA_W +: LANE_DATA_W]    = lane_word[i].data;
        wr_word_next.check[i*LANE_CHECK_W +: LANE_CHECK_W] = lane_word[i].check;
      end
    end
    if (&lane_have_next) begin
      wr_valid_next  = 1'b1;                        // Passed on toward memory
      lane_have_next = '0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      wr_word_reg   <= '0;
      lane_have_reg <= '0;
      wr_valid_reg  <= 1'b0;
    end else begin
      wr_word_reg   <= wr_word_next;
      lane_have_reg <= lane_have_next;
      wr_valid_reg  <= wr_valid_next;
    end
  end

  assign WR_WORD_OUT       = wr_word_reg;
  assign WR_WORD_VALID_OUT = wr_valid_reg;

endmodule

// >>> test/cpu_bus_data_channel_asserts.sv
`timescale 1ns/1ps
// Pin timing and word order of the processor data channel
module cpu_bus_data_channel_asserts
  import cpu_data_pkg::*;
(
  input wire logic               CLOCK_IN,
  input wire logic               RST_IN,
  input wire logic [DATA_W-1:0]  CPU_DATA_LINES_N_OUT,
  input wire logic               CPU_DATA_LINES_OE_OUT,
  input wire logic [CHECK_W-1:0] ECC_CHECK_LINES_N_OUT,
  input wire logic               ECC_CHECK_LINES_OE_OUT,
  input wire logic [LANES-1:0]   FROM_CPU_DATA_STROBES_N_IN,
  input wire logic [LANES-1:0]   TO_CPU_DATA_STROBES_N_OUT,
  input wire logic               TO_CPU_COMMAND_STROBE_N_OUT,
  input wire logic               TO_CPU_DATA_VALID_N_OUT,
  input wire logic               FORWARD_CLOCK_INIT_OUT,
  input wire logic               RELEASE_BUS_IN,
  input wire pair_t              RD_PAIR_IN,
  input wire logic               RD_PAIR_VALID_IN,
  input wire logic               RD_PAIR_READY_OUT,
  input wire logic               WR_WORD_VALID_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  pair_t       pend_reg; // Last pair taken
  pair_t       cur_reg;  // Pair on the pins
  logic        cmd_n;    // All data strobes follow it
  logic [71:0] pins;     // Check and data pin image
  assign cmd_n = TO_CPU_COMMAND_STROBE_N_OUT;
  assign pins = {ECC_CHECK_LINES_N_OUT, CPU_DATA_LINES_N_OUT};
  // Safe with one register: a new take only follows the held pair's start
  always_ff @(posedge CLOCK_IN) begin
    if (RD_PAIR_VALID_IN && RD_PAIR_READY_OUT) begin
      pend_reg <= RD_PAIR_IN;
    end
    if ($fell(cmd_n) && !TO_CPU_DATA_VALID_N_OUT) begin
      cur_reg <= pend_reg;
    end
  end
  a_reset_floats: assert property (disable iff (1'b0)
    RST_IN |-> !CPU_DATA_LINES_OE_OUT && !ECC_CHECK_LINES_OE_OUT) else $error("lines driven in reset");
  a_lines_owner: assert property (
    CPU_DATA_LINES_OE_OUT == !RELEASE_BUS_IN && ECC_CHECK_LINES_OE_OUT == !RELEASE_BUS_IN)
    else $error("line ownership wrong");
  a_strobes_idle: assert property (
    FORWARD_CLOCK_INIT_OUT |-> TO_CPU_DATA_STROBES_N_OUT == {LANES{STROBE_INACTIVE_N}}) else $error("strobe in init");
  a_strobe_start: assert property ($fell(FORWARD_CLOCK_INIT_OUT) |->
    (TO_CPU_DATA_STROBES_N_OUT == 4'hf) [*3] ##[1:8] (TO_CPU_DATA_STROBES_N_OUT == 4'h0)) else $error("strobe start");
  a_lanes_aligned: assert property (
    TO_CPU_DATA_STROBES_N_OUT == {LANES{cmd_n}}) else $error("strobes not aligned");
  a_half_period: assert property ($fell(cmd_n) |-> !cmd_n [*4] ##1 cmd_n) else $error("strobe period");
  a_valid_on_fall: assert property (
    !$past(RST_IN) && $changed(TO_CPU_DATA_VALID_N_OUT) |-> $fell(cmd_n)) else $error("valid off edge");
  a_data_on_edge: assert property (
    !$past(RST_IN) && $changed(pins) |-> $changed(cmd_n)) else $error("data off edge");
  a_first_word: assert property (
    $fell(cmd_n) && !TO_CPU_DATA_VALID_N_OUT |-> pins == ~pend_reg.first) else $error("first word");
  a_second_word: assert property (
    $rose(cmd_n) && !TO_CPU_DATA_VALID_N_OUT |-> pins == ~cur_reg.second) else $error("second word");
  a_write_pulse: assert property (
    !$past(RST_IN) && $changed(FROM_CPU_DATA_STROBES_N_IN) |-> ##[3:7] WR_WORD_VALID_OUT) else $error("no write word");
  c_pair: cover property ($fell(TO_CPU_DATA_VALID_N_OUT));
  c_write: cover property (WR_WORD_VALID_OUT && RELEASE_BUS_IN);
  c_init: cover property ($fell(FORWARD_CLOCK_INIT_OUT));
endmodule
bind cpu_bus_data_channel cpu_bus_data_channel_asserts u_chk (
  .CLOCK_IN                    (CLOCK_IN),
  .RST_IN                      (RST_IN),
  .CPU_DATA_LINES_N_OUT        (CPU_DATA_LINES_N_OUT),
  .CPU_DATA_LINES_OE_OUT       (CPU_DATA_LINES_OE_OUT),
  .ECC_CHECK_LINES_N_OUT       (ECC_CHECK_LINES_N_OUT),
  .ECC_CHECK_LINES_OE_OUT      (ECC_CHECK_LINES_OE_OUT),
  .FROM_CPU_DATA_STROBES_N_IN  (FROM_CPU_DATA_STROBES_N_IN),
  .TO_CPU_DATA_STROBES_N_OUT   (TO_CPU_DATA_STROBES_N_OUT),
  .TO_CPU_COMMAND_STROBE_N_OUT (TO_CPU_COMMAND_STROBE_N_OUT),
  .TO_CPU_DATA_VALID_N_OUT     (TO_CPU_DATA_VALID_N_OUT),
  .FORWARD_CLOCK_INIT_OUT      (FORWARD_CLOCK_INIT_OUT),
  .RELEASE_BUS_IN              (RELEASE_BUS_IN),
  .RD_PAIR_IN                  (RD_PAIR_IN),
  .RD_PAIR_VALID_IN            (RD_PAIR_VALID_IN),
  .RD_PAIR_READY_OUT           (RD_PAIR_READY_OUT),
  .WR_WORD_VALID_OUT           (WR_WORD_VALID_OUT)
);

// >>> test/cpu_side_model.sv
`timescale 1ns/1ps
// Processor side: forwarded write strobes and write words
module cpu_side_model
  import cpu_data_pkg::*;
(
  input  wire logic        clk_in,        // Reference clock
  input  wire logic        init_in,       // Forward-clock init
  input  wire logic        write_in,      // Processor owns the lines
  output logic [LANES-1:0] strobes_n_out, // Write strobes
  output word_t            word_n_out,    // Active-low word image
  output logic             drive_out      // High while driving lines
);
  logic [15:0] seq; // Word number, one per strobe edge
  assign drive_out = write_in;
  initial begin
    strobes_n_out = '1;
    word_n_out = '1;
    seq = '0;
  end
  // Strobes idle in init, then free-running at an unrelated phase
  always begin
    wait (init_in === 1'b1);
    strobes_n_out = {LANES{STROBE_INACTIVE_N}};
    wait (init_in === 1'b0);
    repeat (3) @(posedge clk_in);
    #137;
    while (init_in === 1'b0) begin
      strobes_n_out = ~strobes_n_out; // Each edge moves a word
      word_n_out = ~{8'(seq) ^ 8'h5a, seq + 16'h3000, seq + 16'h2000, seq + 16'h1000, seq};
      seq = seq + 16'h1;
      repeat (4) if (init_in === 1'b0) #100;
    end
  end
endmodule

// >>> test/cpu_bus_data_channel_test.sv
`timescale 1ns/1ps
// Drives the channel from the user side against a processor model
module cpu_bus_data_channel_test;
  import cpu_data_pkg::*;
  logic             clock, rst, release_bus, rd_valid; // Bench-driven inputs
  pair_t            rd_pair;         // Read pair offered
  word_t            float_n;         // Undriven lines drift every cycle
  wire logic [63:0] pin_data;        // Resolved data lines
  wire logic [7:0]  pin_check;       // Resolved check lines
  logic [63:0]      data_n;
  logic [7:0]       check_n;
  logic             data_oe, check_oe, cmd_n, valid_n, fwd_init, rd_ready, wr_valid, cmd_prev, cpu_drive;
  logic [3:0]       to_strobes_n, cpu_strobes_n;
  word_t            wr_word, cpu_word_n;
  word_t            got_q[$];        // Words seen going to the processor
  int               err_count, samples_checked, cycles;
  assign pin_data = data_oe ? data_n : cpu_drive ? cpu_word_n.data : float_n.data;
  assign pin_check = check_oe ? check_n : cpu_drive ? cpu_word_n.check : float_n.check;
  cpu_bus_data_channel dut (.CLOCK_IN(clock), .RST_IN(rst), .CPU_DATA_LINES_N_IN(pin_data),
    .CPU_DATA_LINES_N_OUT(data_n), .CPU_DATA_LINES_OE_OUT(data_oe), .ECC_CHECK_LINES_N_IN(pin_check),
    .ECC_CHECK_LINES_N_OUT(check_n), .ECC_CHECK_LINES_OE_OUT(check_oe), .FROM_CPU_DATA_STROBES_N_IN(cpu_strobes_n),
    .TO_CPU_DATA_STROBES_N_OUT(to_strobes_n), .TO_CPU_COMMAND_STROBE_N_OUT(cmd_n), .TO_CPU_DATA_VALID_N_OUT(valid_n),
    .FORWARD_CLOCK_INIT_OUT(fwd_init), .RELEASE_BUS_IN(release_bus), .RD_PAIR_IN(rd_pair), .RD_PAIR_VALID_IN(rd_valid),
    .RD_PAIR_READY_OUT(rd_ready), .WR_WORD_OUT(wr_word), .WR_WORD_VALID_OUT(wr_valid));
  cpu_side_model partner (.clk_in(clock), .init_in(fwd_init), .write_in(release_bus),
    .strobes_n_out(cpu_strobes_n), .word_n_out(cpu_word_n), .drive_out(cpu_drive));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Free lines change each cycle; counts cycles against a hang
  always @(posedge clock) begin
    float_n <= ~{pin_check, pin_data};
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  // Logs each word handed over while valid is low
  always @(negedge clock) begin
    if (!rst && cmd_n !== cmd_prev && valid_n === 1'b0) got_q.push_back(~{check_n, data_n});
    cmd_prev = cmd_n;
  end
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic word_t exp_word(input logic [15:0] s);
    return {8'(s) ^ 8'h5a, s + 16'h3000, s + 16'h2000, s + 16'h1000, s};
  endfunction
  // Reset for ten cycles, then time init release and start of running
  task automatic do_reset;
    int n;
    @(posedge clock);
    rst <= 1'b1;
    repeat (9) @(posedge clock);
    // Looked at while reset still stands; the enables follow reset at once
    #1 check({data_oe, check_oe, to_strobes_n, valid_n, fwd_init, rd_ready}, 9'h07e);
    @(posedge clock);
    rst <= 1'b0;
    n = 0;
    while (fwd_init === 1'b1 && n < 30) begin
      @(posedge clock);
      #1 n++;
    end
    check(n, int'(FWD_INIT_HOLD_LAST) + 1);
    n = 0;
    while (rd_ready !== 1'b1 && n < 30) begin
      @(posedge clock);
      #1 n++;
    end
    check(n, int'(STROBE_START_LAST) + 1);
    @(posedge clock);
  endtask
  // Offers a pair and holds it until taken; the caller lowers valid
  task automatic send_pair(input pair_t p);
    rd_pair <= p;
    rd_valid <= 1'b1;
    @(negedge clock);
    while (rd_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
  endtask
  // Two pairs back to back, an idle gap, one more; lines then hold
  task automatic read_pairs;
    pair_t p[3];
    for (int i = 0; i < 3; i++) p[i] = {8'(i) ^ 8'hc3, 64'h0123456789abcdef + 64'(i), 8'(i) ^ 8'h3c, ~64'(i)};
    got_q.delete();
    send_pair(p[0]);
    send_pair(p[1]);
    rd_valid <= 1'b0;
    repeat (30) @(posedge clock);
    send_pair(p[2]);
    rd_valid <= 1'b0;
    repeat (30) @(posedge clock);
    check(got_q.size(), 6);
    for (int k = 0; k < 3; k++) begin
      check(got_q[2*k], p[k].first);
      check(got_q[2*k+1], p[k].second);
    end
    check({data_oe, check_oe, ~{check_n, data_n}}, {2'b11, p[2].second});
  endtask
  // Processor writes a stream; every lane must reach the user side
  task automatic write_words;
    logic [15:0] k;
    release_bus <= 1'b1;
    repeat (12) @(posedge clock);
    #1 check({data_oe, check_oe}, 2'b00);
    for (int i = 0; i < 6; i++) begin
      @(negedge clock);
      while (wr_valid !== 1'b1) @(negedge clock);
      if (i == 0) k = wr_word.data[15:0];
      check(wr_word, exp_word(k + 16'(i)));
    end
    @(posedge clock);
    release_bus <= 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    release_bus = 1'b0;
    rd_valid = 1'b0;
    rd_pair = '0;
    float_n = '1;
    do_reset();
    read_pairs();
    write_words();
    rd_valid <= 1'b1;
    repeat (20) @(posedge clock);
    rd_valid <= 1'b0;
    do_reset();
    read_pairs();
    finish_test();
  end
endmodule
